// [prwc_defs.svh]
`ifndef PRWC_DEFS_SVH
`define PRWC_DEFS_SVH

// ****************************************
// special function register addresses
// ****************************************
`define PRWC_POWER_CONTROL_REG_ADDR      8'h87
`define PRWC_PLL_CONTROL_REG_ADDR    8'hD7
`define PRWC_PARTID_ADDR    8'hC2

// ****************************************
// field positions
// ****************************************
`define PRWC_POWER_CONTROL_REG_PD_BIT    1
`define PRWC_POWER_CONTROL_REG_SERW_BIT  5
`define PRWC_POWER_CONTROL_REG_EXT0W_BIT 6
`define PRWC_PLL_OSCH_BIT   7
`define PRWC_PLL_LOCK_BIT   6
`define PRWC_PLL_CD_LSB     0
`define PRWC_PLL_CD_W       3

// ****************************************
// reset values
// ****************************************
`define PRWC_POWER_CONTROL_REG_RST       8'h00
`define PRWC_PLL_CD_RST     3'h3
`define PRWC_PART_ID        8'h50

// ****************************************
// timing
// ****************************************
`define PRWC_CLK_KHZ        125000
`define PRWC_POR_MS         128
`define PRWC_XTAL_MS        150
`define PRWC_LOCK_MS        1
`define PRWC_POR_CYC        (`PRWC_POR_MS * `PRWC_CLK_KHZ)
`define PRWC_XTAL_CYC       (`PRWC_XTAL_MS * `PRWC_CLK_KHZ)
`define PRWC_LOCK_CYC       (`PRWC_LOCK_MS * `PRWC_CLK_KHZ)
`define PRWC_PLL_MULT       384
`define PRWC_XTAL_HZ        32768

`endif

// [prwc_pkg.sv]
package prwc_pkg;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        PRWC_POR_WAIT,
        PRWC_PLL_LOCK,
        PRWC_RUN,
        PRWC_PDOWN,
        PRWC_XTAL_START
    } prwc_state_t;

    // ****************************************
    // pin states held in power-down
    // ****************************************
    typedef struct packed {
        logic port_hold;
        logic dac_hiz;
        logic ale_low;
        logic prog_store_strobe_low;
    } prwc_pins_t;

    // ****************************************
    // special function register access
    // ****************************************
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } prwc_sfr_req_t;

endpackage : prwc_pkg

// [prwc_top.sv]
`timescale 1ns/1ps
`include "prwc_defs.svh"
module prwc_top
    import prwc_pkg::*;
#(
    parameter int         POR_CYC  = `PRWC_POR_CYC,
    parameter int         XTAL_CYC = `PRWC_XTAL_CYC,
    parameter int         LOCK_CYC = `PRWC_LOCK_CYC,
    parameter int         CNT_W    = 25,
    parameter logic [7:0] PART_ID  = `PRWC_PART_ID
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     supply_above_por,
    input  wire logic                     supply_above_1v,
    input  wire logic                     reset_pin,
    input  wire logic                     ext_irq_zero,
    input  wire logic                     ext_irq_zero_en,
    input  wire logic                     spi_irq,
    input  wire logic                     spi_irq_en,
    input  wire logic                     tic_irq,
    input  wire logic                     tic_en,
    input  wire prwc_sfr_req_t            sfr_req,
    output logic [7:0]                    sfr_rdata_q,
    output logic                          core_rst_q,
    output logic                          core_clk_en_q,
    output logic                          pll_run_q,
    output logic                          osc_run_q,
    output logic                          tic_run_q,
    output logic                          periph_en_q,
    output logic [`PRWC_PLL_CD_W-1:0]     core_clock_divider_q,
    output logic                          wake_irq_q,
    output prwc_pins_t                    pd_pins_q
);

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] off);
        sfr_hit = (a == off);
    endfunction : sfr_hit

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int NSYNC = 4;

    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] filt_q;

    assign async_in = {ext_irq_zero, reset_pin, supply_above_1v, supply_above_por};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    s1_q[gi]   <= 1'b0;
                    s2_q[gi]   <= 1'b0;
                    s3_q[gi]   <= 1'b0;
                    filt_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= async_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        filt_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    wire above_por = filt_q[0];
    wire above_1v  = filt_q[1];
    wire pin_rst   = filt_q[2];
    wire ext0_lvl  = filt_q[3];

    // ****************************************
    // state and registers
    // ****************************************
    prwc_state_t              state_q;
    prwc_state_t              state_d;
    logic [CNT_W-1:0]         cnt_q;
    logic [CNT_W-1:0]         cnt_d;
    logic                     pd_q;
    logic                     pd_d;
    logic                     serw_q;
    logic                     ext0w_q;
    logic                     osch_q;
    logic [`PRWC_PLL_CD_W-1:0] cd_q;

    // ****************************************
    // power-on and pin reset
    // ****************************************
    wire supply_off = !above_por || !above_1v;
    wire soft_clr   = supply_off || pin_rst
                    || (state_q == PRWC_POR_WAIT);

    // ****************************************
    // register access
    // ****************************************
    wire wr_power_control_reg = sfr_req.wr && sfr_hit(sfr_req.addr, `PRWC_POWER_CONTROL_REG_ADDR);
    wire wr_pll  = sfr_req.wr && sfr_hit(sfr_req.addr, `PRWC_PLL_CONTROL_REG_ADDR);
    wire rd_power_control_reg = sfr_hit(sfr_req.addr, `PRWC_POWER_CONTROL_REG_ADDR);
    wire rd_pll  = sfr_hit(sfr_req.addr, `PRWC_PLL_CONTROL_REG_ADDR);
    wire rd_id   = sfr_hit(sfr_req.addr, `PRWC_PARTID_ADDR);

    wire locked  = (state_q == PRWC_RUN);

    logic [7:0] power_control_reg_view;
    logic [7:0] pll_view;
    logic [7:0] rdata_d;

    always_comb begin
        power_control_reg_view = 8'h00;
        power_control_reg_view[`PRWC_POWER_CONTROL_REG_PD_BIT]    = pd_q;
        power_control_reg_view[`PRWC_POWER_CONTROL_REG_SERW_BIT]  = serw_q;
        power_control_reg_view[`PRWC_POWER_CONTROL_REG_EXT0W_BIT] = ext0w_q;
        pll_view = 8'h00;
        pll_view[`PRWC_PLL_OSCH_BIT] = osch_q;
        pll_view[`PRWC_PLL_LOCK_BIT] = locked;
        pll_view[`PRWC_PLL_CD_LSB +: `PRWC_PLL_CD_W] = cd_q;
    end

    assign rdata_d = !sfr_req.rd ? 8'h00 :
                     rd_power_control_reg     ? power_control_reg_view :
                     rd_pll      ? pll_view :
                     rd_id       ? PART_ID :
                                   8'h00;

    // ****************************************
    // wake sources
    // ****************************************
    wire wake_tic  = tic_irq && tic_en && !osch_q;
    wire wake_spi  = spi_irq && spi_irq_en && serw_q;
    wire wake_ext0 = ext0_lvl && ext_irq_zero_en && ext0w_q;
    wire in_pdown  = (state_q == PRWC_PDOWN);
    wire wake      = in_pdown && (wake_tic || wake_spi || wake_ext0);

    // ****************************************
    // power-down bit
    // ****************************************
    assign pd_d = soft_clr ? 1'b0 :
                  wake     ? 1'b0 :
                  wr_power_control_reg  ? sfr_req.wdata[`PRWC_POWER_CONTROL_REG_PD_BIT] :
                             pd_q;

    // ****************************************
    // sequencer
    // ****************************************
    wire por_done  = (cnt_q == CNT_W'(POR_CYC - 1));
    wire xtal_done = (cnt_q == CNT_W'(XTAL_CYC - 1));
    wire lock_done = (cnt_q == CNT_W'(LOCK_CYC - 1));
    wire [CNT_W-1:0] cnt_inc = cnt_q + CNT_W'(1);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_inc;
        if (supply_off) begin
            state_d = PRWC_POR_WAIT;
            cnt_d   = '0;
        end else if (pin_rst && state_q != PRWC_POR_WAIT) begin
            state_d = PRWC_PLL_LOCK;
            cnt_d   = '0;
        end else begin
            unique case (state_q)
                PRWC_POR_WAIT: begin
                    if (por_done) begin
                        state_d = PRWC_PLL_LOCK;
                        cnt_d   = '0;
                    end
                end
                PRWC_PLL_LOCK: begin
                    if (lock_done) begin
                        state_d = PRWC_RUN;
                        cnt_d   = '0;
                    end
                end
                PRWC_RUN: begin
                    cnt_d = '0;
                    if (pd_q) begin
                        state_d = PRWC_PDOWN;
                    end
                end
                PRWC_PDOWN: begin
                    cnt_d = '0;
                    if (wake) begin
                        state_d = osch_q ? PRWC_XTAL_START
                                         : PRWC_PLL_LOCK;
                    end
                end
                PRWC_XTAL_START: begin
                    if (xtal_done) begin
                        state_d = PRWC_PLL_LOCK;
                        cnt_d   = '0;
                    end
                end
                default: begin
                    state_d = PRWC_POR_WAIT;
                    cnt_d   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= PRWC_POR_WAIT;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pd_q    <= 1'b0;
            serw_q  <= 1'b0;
            ext0w_q <= 1'b0;
            osch_q  <= 1'b0;
            cd_q    <= `PRWC_PLL_CD_RST;
        end else if (soft_clr) begin
            pd_q    <= 1'b0;
            serw_q  <= 1'b0;
            ext0w_q <= 1'b0;
            osch_q  <= 1'b0;
            cd_q    <= `PRWC_PLL_CD_RST;
        end else begin
            pd_q <= pd_d;
            if (wr_power_control_reg) begin
                serw_q  <= sfr_req.wdata[`PRWC_POWER_CONTROL_REG_SERW_BIT];
                ext0w_q <= sfr_req.wdata[`PRWC_POWER_CONTROL_REG_EXT0W_BIT];
            end
            if (wr_pll) begin
                osch_q <= sfr_req.wdata[`PRWC_PLL_OSCH_BIT];
                cd_q   <= sfr_req.wdata[`PRWC_PLL_CD_LSB +: `PRWC_PLL_CD_W];
            end
        end
    end

    // ****************************************
    // output decode
    // ****************************************
    wire        st_por   = (state_q == PRWC_POR_WAIT);

    // ****************************************
    // next-state view
    // ****************************************
    // core clock enable back on in the same edge that raises the wake pulse; PLL and oscillator stay off while in PRWC_XTAL_START
    wire        nx_por   = (state_d == PRWC_POR_WAIT);
    wire        nx_pdown = (state_d == PRWC_PDOWN);
    wire        nx_xtal  = (state_d == PRWC_XTAL_START);

    logic       rst_d;
    logic       clk_en_d;
    logic       pll_d;
    logic       osc_d;
    logic       tic_d;
    logic       per_d;
    logic       wirq_d;
    prwc_pins_t pins_d;

    assign rst_d    = st_por || supply_off || pin_rst;
    assign clk_en_d = !nx_por && !nx_pdown && !supply_off;
    assign pll_d    = clk_en_d && !nx_xtal;
    assign osc_d    = !supply_off
                      && !((nx_pdown || nx_xtal) && osch_q);
    assign tic_d    = osc_d && tic_en;
    assign per_d    = clk_en_d;
    assign wirq_d   = wake && !soft_clr;

    assign pins_d = '{port_hold:             nx_pdown,
                      dac_hiz:               nx_pdown,
                      ale_low:               nx_pdown,
                      prog_store_strobe_low: nx_pdown};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sfr_rdata_q          <= 8'h00;
            core_rst_q           <= 1'b1;
            core_clk_en_q        <= 1'b0;
            pll_run_q            <= 1'b0;
            osc_run_q            <= 1'b0;
            tic_run_q            <= 1'b0;
            periph_en_q          <= 1'b0;
            core_clock_divider_q <= `PRWC_PLL_CD_RST;
            wake_irq_q           <= 1'b0;
            pd_pins_q            <= '0;
        end else begin
            sfr_rdata_q          <= rdata_d;
            core_rst_q           <= rst_d;
            core_clk_en_q        <= clk_en_d;
            pll_run_q            <= pll_d;
            osc_run_q            <= osc_d;
            tic_run_q            <= tic_d;
            periph_en_q          <= per_d;
            core_clock_divider_q <= cd_q;
            wake_irq_q           <= wirq_d;
            pd_pins_q            <= pins_d;
        end
    end

endmodule : prwc_top

// [prwc_asserts.sv]
`timescale 1ns/1ps
`include "prwc_defs.svh"
// ****************************************
// port checks
// ****************************************
module prwc_asserts
    import prwc_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h50
) (
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 supply_above_por,
    input wire logic                 supply_above_1v,
    input wire logic                 reset_pin,
    input wire logic                 ext_irq_zero,
    input wire logic                 ext_irq_zero_en,
    input wire logic                 spi_irq,
    input wire logic                 spi_irq_en,
    input wire logic                 tic_irq,
    input wire logic                 tic_en,
    input wire prwc_sfr_req_t        sfr_req,
    input wire logic [7:0]           sfr_rdata_q,
    input wire logic                 core_rst_q,
    input wire logic                 core_clk_en_q,
    input wire logic                 pll_run_q,
    input wire logic                 osc_run_q,
    input wire logic                 tic_run_q,
    input wire logic                 periph_en_q,
    input wire logic [`PRWC_PLL_CD_W-1:0] core_clock_divider_q,
    input wire logic                 wake_irq_q,
    input wire prwc_pins_t           pd_pins_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire pd_on = pd_pins_q.port_hold;
    wire pd_wr = sfr_req.wr && sfr_req.addr == 8'h87 && sfr_req.wdata[1] && !core_rst_q
                 && core_clk_en_q;
    wire unmap = sfr_req.rd && sfr_req.addr != 8'h87 && sfr_req.addr != 8'hD7
                 && sfr_req.addr != 8'hC2;

    chk_pd_entry: assert property (pd_wr |-> ##3 (!core_clk_en_q || wake_irq_q))
        else $error("power-down not entered");
    chk_pd_clocks_off: assert property (pd_on |-> !core_clk_en_q && !pll_run_q && !periph_en_q)
        else $error("clocks or peripherals running in power-down");
    chk_pd_pins_all: assert property (pd_on |-> pd_pins_q == 4'hF)
        else $error("pin states wrong in power-down");
    chk_tic_needs_osc: assert property (tic_run_q |-> osc_run_q)
        else $error("interval counter running without oscillator");
    chk_wake_one_pulse: assert property (wake_irq_q |=> !wake_irq_q)
        else $error("wake pulse longer than one cycle");
    chk_wake_clk_on: assert property (wake_irq_q |-> core_clk_en_q && !pd_on)
        else $error("wake without clock restart");
    chk_id_read: assert property (sfr_req.rd && sfr_req.addr == 8'hC2 && !core_rst_q
                                  |=> sfr_rdata_q == PART_ID)
        else $error("identification read wrong");
    chk_unmapped_zero: assert property (unmap |=> sfr_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    chk_pin_reset: assert property ($rose(reset_pin) |-> ##[1:8] core_rst_q)
        else $error("reset pin ignored");
    chk_supply_low: assert property (!supply_above_por [*8] |-> core_rst_q)
        else $error("core out of reset on low supply");

    cover property (wake_irq_q && ext_irq_zero);
    cover property (pd_on && !osc_run_q);
    cover property ($fell(core_rst_q));
endmodule : prwc_asserts

// [prwc_top_tb.sv]
`timescale 1ns/1ps
`include "prwc_defs.svh"
// ****************************************
// bench
// ****************************************
module prwc_top_tb;
    import prwc_pkg::*;
    localparam int         POR = 20;
    localparam int         XT  = 30;
    localparam int         LK  = 10;
    localparam logic [7:0] ID  = 8'h5A; // arbitrary value
    logic          clk_sys = 1'b0;
    logic          rst     = 1'b1;
    logic          sup_por = 1'b0;
    logic          sup_1v  = 1'b1;
    logic          rpin    = 1'b0;
    logic [5:0]    irq     = 6'h00;
    prwc_sfr_req_t req     = '0;
    logic [7:0]    rdata;
    logic [7:0]    rd_v;
    logic [2:0]    cdiv;
    logic          core_rst, clk_en, pll_run, osc_run, tic_run, per_en, wake;
    prwc_pins_t    pins;
    int            error_cnt = 0;
    int            n_checks  = 0;

    always #4 clk_sys = ~clk_sys;

    prwc_top #(.POR_CYC(POR), .XTAL_CYC(XT), .LOCK_CYC(LK), .PART_ID(ID)) u_prwc_top (
        .clk_sys(clk_sys), .rst(rst), .supply_above_por(sup_por), .supply_above_1v(sup_1v),
        .reset_pin(rpin), .ext_irq_zero(irq[0]), .ext_irq_zero_en(irq[1]),
        .spi_irq(irq[2]), .spi_irq_en(irq[3]), .tic_irq(irq[4]), .tic_en(irq[5]),
        .sfr_req(req), .sfr_rdata_q(rdata), .core_rst_q(core_rst), .core_clk_en_q(clk_en),
        .pll_run_q(pll_run), .osc_run_q(osc_run), .tic_run_q(tic_run), .periph_en_q(per_en),
        .core_clock_divider_q(cdiv), .wake_irq_q(wake), .pd_pins_q(pins));

    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        cyc(1);
        req = '0;
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a);
        cyc(1);
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        cyc(1);
        rd_v = rdata;
        req = '0;
    endtask : sfr_rd

    task automatic wait_lock(output int n);
        n = 0;
        do begin
            sfr_rd(8'hD7);
            n++;
        end while (!rd_v[6] && n < 200);
        chk("lock bit", rd_v[6], 8'h01);
    endtask : wait_lock

    task automatic t_por;
        int n = 0;
        while (core_rst !== 1'b0 && n < 200) begin
            cyc(1);
            n++;
        end
        chk("por wait", n > POR && n < POR + 12, 8'h01);
    endtask : t_por

    task automatic t_regs;
        sfr_rd(8'hC2);
        chk("id", rd_v, ID);
        sfr_wr(8'hC2, 8'hFF);
        sfr_rd(8'hC2);
        chk("id read only", rd_v, ID);
        sfr_rd(8'h80);
        chk("unmapped", rd_v, 8'h00);
        chk("divider reset", cdiv, 8'h03);
        sfr_wr(8'hD7, 8'h05);
        cyc(1);
        chk("divider set", cdiv, 8'h05);
    endtask : t_regs

    task automatic t_wake(input int b, input logic [7:0] power_control_reg, input logic [7:0] pll,
                          input logic [5:0] en, input logic w);
        int n = 0;
        irq = en;
        sfr_wr(8'hD7, pll);
        sfr_wr(8'h87, power_control_reg | 8'h02);
        cyc(4);
        chk("pd clock", {pll_run, clk_en, per_en}, 8'h00);
        chk("pd pins", pins, 8'h0F);
        chk("pd osc", osc_run, !pll[7]);
        chk("pd tic", tic_run, !pll[7] && en[5]);
        irq[b] = 1'b1;
        while (wake !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        chk("wake", wake, w);
        irq[b] = 1'b0;
        if (w) begin
            chk("wake clock", clk_en, 8'h01);
            sfr_rd(8'h87);
            chk("pd bit cleared", rd_v[1], 8'h00);
            wait_lock(n);
            chk("lock time", pll[7] ? 2 * n > XT : 2 * n <= LK + 10, 8'h01);
        end else begin
            rpin = 1'b1;
            cyc(8);
            chk("pin reset", core_rst, 8'h01);
            rpin = 1'b0;
            cyc(10);
            chk("pin release", core_rst, 8'h00);
            sfr_rd(8'h87);
            chk("power_control_reg default", rd_v, 8'h00);
            chk("divider default", cdiv, 8'h03);
            wait_lock(n);
        end
    endtask : t_wake

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        int n;
        cyc(4);
        rst = 1'b0;
        cyc(40);
        chk("held low supply", core_rst, 8'h01);
        sup_por = 1'b1;
        t_por();
        wait_lock(n);
        t_regs();
        t_wake(4, 8'h00, 8'h03, 6'h20, 1'b1);
        t_wake(2, 8'h20, 8'h03, 6'h08, 1'b1);
        t_wake(0, 8'h40, 8'h03, 6'h02, 1'b1);
        t_wake(2, 8'h00, 8'h03, 6'h08, 1'b0);
        t_wake(4, 8'h00, 8'h83, 6'h20, 1'b0);
        t_wake(0, 8'h40, 8'h83, 6'h02, 1'b1);
        sup_por = 1'b0;
        cyc(10);
        chk("supply drop", core_rst, 8'h01);
        sup_por = 1'b1;
        t_por();
        test_done();
    end

    initial begin
        #50000;
        error_cnt++;
        test_done();
    end
endmodule : prwc_top_tb

bind prwc_top prwc_asserts #(.PART_ID(PART_ID)) u_prwc_asserts (
    .clk_sys(clk_sys), .rst(rst), .supply_above_por(supply_above_por),
    .supply_above_1v(supply_above_1v), .reset_pin(reset_pin), .ext_irq_zero(ext_irq_zero),
    .ext_irq_zero_en(ext_irq_zero_en), .spi_irq(spi_irq), .spi_irq_en(spi_irq_en),
    .tic_irq(tic_irq), .tic_en(tic_en), .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q),
    .core_rst_q(core_rst_q), .core_clk_en_q(core_clk_en_q), .pll_run_q(pll_run_q),
    .osc_run_q(osc_run_q), .tic_run_q(tic_run_q), .periph_en_q(periph_en_q),
    .core_clock_divider_q(core_clock_divider_q), .wake_irq_q(wake_irq_q),
    .pd_pins_q(pd_pins_q));
